// ### core/ls_addr_front_end.sv
`timescale 1ns/1ps
// Load/store address front end: registers, address path and memory bus cycle
module ls_addr_front_end (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Load/store requests
  input wire logic req_valid,
  input wire logic [31:0] req_base,
  input wire logic [31:0] req_offset,
  input wire ls_front_pkg::access_size_t req_size,
  input wire ls_front_pkg::access_kind_t req_kind,
  input wire logic req_write,
  input wire logic [31:0] req_wdata,
  input wire logic [31:0] req_frame_base,
  input wire logic req_large_page,
  output logic req_ready,
  output logic resp_valid,
  output logic [31:0] resp_rdata,
  output logic resp_fault,
  output logic align_trap,
  output logic bus_trap,
  // External memory bus
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic burst_ready_in_n,
  input wire logic bus_error_in,
  input wire logic parity_check_enable_n,
  // Internal concurrency unit
  output logic ccu_req,
  output logic ccu_write,
  output logic [31:0] ccu_addr,
  output logic [31:0] ccu_wdata,
  input wire logic ccu_ack,
  input wire logic [31:0] ccu_rdata,
  // Mode
  output logic translation_enable
);
  import ls_front_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_CCU} state_t;

  // ******************************
  // Declarations
  // ******************************
  state_t state;
  logic [31:0] bus_fault_address;
  logic [31:0] concurrency_config;
  logic big_endian_select;
  logic fault_armed;
  logic [34:0] pin_meta;
  logic [34:0] pin_sync;
  logic sync_ready;
  logic sync_error;
  logic sync_parity;
  logic [31:0] sync_rdata;
  logic [31:0] eff_addr;
  logic [31:0] phys_addr;
  logic misaligned;
  logic internal_ccu;
  logic in_window;
  logic divert;
  logic accept;
  logic swap_ok;
  logic cur_swap;
  access_size_t cur_size;
  logic apb_done;
  logic apb_setup_done;
  logic fault_read;
  logic bus_fault_ev;
  logic [31:0] read_mux;

  // ******************************
  // Helpers
  // ******************************
  // Byte order for a 32-bit lane; wider items swap per word
  function automatic logic [31:0] order_bytes(input logic [31:0] d, input access_size_t sz,
                                             input logic flip);
    logic [31:0] r;
    r = d;
    if (flip && sz == SZ_16) begin
      r = {d[31:16], d[7:0], d[15:8]};
    end else if (flip && sz != SZ_8) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
    return r;
  endfunction

  // Access refused: unmapped, read-only write, or user write to privileged
  function automatic logic apb_err(input logic [7:0] a, input logic wr, input logic priv);
    logic e;
    e = 1'b1;
    if (a == OFF_FAULT_ADDR || a == OFF_STATUS) begin
      e = wr;
    end else if (a == OFF_CONC_CFG || a == OFF_MODE_CTRL) begin
      e = wr && !priv;
    end
    return e;
  endfunction

  // ******************************
  // Pin synchroniser
  // ******************************
  // Two stages on ready, error, parity enable and read data together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= {burst_ready_in_n, bus_error_in, parity_check_enable_n, mem_rdata};
      pin_sync <= pin_meta;
    end
  end

  assign sync_ready = !pin_sync[34];
  assign sync_error = pin_sync[33];
  assign sync_parity = !pin_sync[32];
  assign sync_rdata = pin_sync[31:0];

  // ******************************
  // Address path
  // ******************************
  // [R11] wrapping sum, carry out dropped
  assign eff_addr = req_base + req_offset;

  ls_align_check u_align (
    .size(req_size),
    .addr_low(eff_addr[3:0]),
    .misaligned(misaligned)
  );

  // Table walks already carry physical addresses
  ls_page_frame u_frame (
    .enable(translation_enable && req_kind != KIND_TABLE),
    .large_page(req_large_page),
    .virt_addr(eff_addr),
    .frame_base(req_frame_base),
    .phys_addr(phys_addr)
  );

  // [R8] only both bits set selects the internal unit
  assign internal_ccu = concurrency_config[CFG_CO_BIT] && concurrency_config[CFG_DO_BIT];
  // [R10] base bit 12 is held clear, so the window spans two pages
  assign in_window = eff_addr[31:CFG_BASE_LSB] == concurrency_config[31:CFG_BASE_LSB];
  assign divert = internal_ccu && in_window && req_kind == KIND_DATA;
  assign accept = req_valid && req_ready;
  // [R13] fetches and [R14] table walks never swap; [R16] I/O does
  assign swap_ok = big_endian_select && (req_kind == KIND_DATA || req_kind == KIND_IO);

  // ******************************
  // Access sequencer
  // ******************************
  // One access in flight; a new request is taken only from idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0000_0000;
      resp_fault <= 1'b0;
      align_trap <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      ccu_req <= 1'b0;
      ccu_write <= 1'b0;
      ccu_addr <= 32'h0000_0000;
      ccu_wdata <= 32'h0000_0000;
      cur_size <= SZ_8;
      cur_swap <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      align_trap <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          req_ready <= !sync_ready; // Stale ready must drain first
          if (accept) begin
            req_ready <= 1'b0;
            cur_size <= req_size;
            cur_swap <= swap_ok;
            if (misaligned) begin
              // [R21] trap without any cycle or capture
              align_trap <= 1'b1;
              resp_valid <= 1'b1;
              resp_fault <= 1'b1;
            end else if (divert) begin
              // [R9] window access goes to the internal unit
              ccu_req <= 1'b1;
              ccu_write <= req_write;
              ccu_addr <= eff_addr;
              ccu_wdata <= order_bytes(req_wdata, req_size, swap_ok);
              state <= ST_CCU;
            end else begin
              // [R12] most significant byte first when selected
              mem_req <= 1'b1;
              mem_write <= req_write;
              mem_addr <= phys_addr;
              mem_wdata <= order_bytes(req_wdata, req_size, swap_ok);
              state <= ST_BUS;
            end
          end
        end
        ST_BUS: begin
          if (sync_ready) begin
            mem_req <= 1'b0;
            resp_valid <= 1'b1;
            resp_rdata <= order_bytes(sync_rdata, cur_size, cur_swap);
            resp_fault <= sync_error || (sync_parity && !mem_write);
            state <= ST_IDLE;
          end
        end
        ST_CCU: begin
          if (ccu_ack) begin
            ccu_req <= 1'b0;
            resp_valid <= 1'b1;
            resp_rdata <= order_bytes(ccu_rdata, cur_size, cur_swap);
            resp_fault <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ******************************
  // Fault address capture
  // ******************************
  assign apb_done = psel && penable && pready;
  assign apb_setup_done = psel && penable && !pready;
  assign fault_read = apb_done && !pwrite && paddr == OFF_FAULT_ADDR;
  // [R1] error and [R2] read parity only count with ready
  assign bus_fault_ev = state == ST_BUS && sync_ready
                        && (sync_error || (sync_parity && !mem_write));

  // [R5] capture disarms; reading the register re-arms
  // An error in the reading cycle wins only while armed; while disarmed it is lost and the read re-arms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_fault_address <= FAULT_RESET;
      fault_armed <= 1'b0;
      bus_trap <= 1'b0;
    end else begin
      bus_trap <= 1'b0;
      // [R3] unqualified or unarmed errors ignored
      if (bus_fault_ev && fault_armed) begin
        // [R4] eight-byte granular address
        bus_fault_address <= {mem_addr[31:FAULT_LSB], {FAULT_LSB{1'b0}}};
        fault_armed <= 1'b0;
        bus_trap <= 1'b1;
      end else if (fault_read) begin
        fault_armed <= 1'b1;
      end
    end
  end

  // ******************************
  // Register writes
  // ******************************
  // [R7] privileged writes only; [R6] fault address never written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      concurrency_config <= CFG_RESET;
      big_endian_select <= 1'b0;
      // [R19] translation off after reset
      translation_enable <= 1'b0;
    end else if (apb_done && pwrite && !apb_err(paddr, 1'b1, pprot[0])) begin
      if (paddr == OFF_CONC_CFG) begin
        concurrency_config <= pwdata & CFG_WMASK;
      end
      if (paddr == OFF_MODE_CTRL) begin
        big_endian_select <= pwdata[CTRL_BE_BIT];
        translation_enable <= pwdata[CTRL_ATE_BIT];
      end
    end
  end

  // ******************************
  // Register reads and APB answer
  // ******************************
  // Reserved bits read as zero
  always_comb begin
    read_mux = 32'h0000_0000;
    if (paddr == OFF_FAULT_ADDR) begin
      read_mux = bus_fault_address;
    end else if (paddr == OFF_CONC_CFG) begin
      read_mux = concurrency_config;
    end else if (paddr == OFF_MODE_CTRL) begin
      read_mux[CTRL_BE_BIT] = big_endian_select;
      read_mux[CTRL_ATE_BIT] = translation_enable;
    end else if (paddr == OFF_STATUS) begin
      read_mux[STAT_ARMED_BIT] = fault_armed;
      read_mux[STAT_BUSY_BIT] = state != ST_IDLE;
    end
  end

  // One wait cycle per transfer keeps data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup_done;
      if (apb_setup_done) begin
        pslverr <= apb_err(paddr, pwrite, pprot[0]);
        prdata <= pwrite ? 32'h0000_0000 : read_mux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_armed_error;
    fault_armed && bus_fault_ev;
  endsequence

  sequence s_armed_parity;
    fault_armed && state == ST_BUS && sync_ready && sync_parity && !mem_write;
  endsequence

  a_fault_capture: assert property ( // [R1]
    s_armed_error |=> bus_trap && !fault_armed
      && bus_fault_address[31:3] == $past(mem_addr[31:3]))
    else $error("bus fault address not captured");

  a_parity_capture: assert property ( // [R2]
    s_armed_parity |=> bus_fault_address == {$past(mem_addr[31:3]), 3'b000})
    else $error("parity fault address wrong");

  a_trap_blocked: assert property ( // [R5]
    !fault_armed |=> !bus_trap)
    else $error("bus trap raised while blocked");

  a_rearm_read: assert property ( // [R5]
    fault_read && !bus_fault_ev |=> fault_armed ##1 fault_armed || bus_trap)
    else $error("read did not re-arm capture");

  a_fault_readonly: assert property ( // [R6]
    apb_done && pwrite && paddr == OFF_FAULT_ADDR && !bus_fault_ev
      |=> $stable(bus_fault_address) && !pready)
    else $error("fault address changed by write");

  a_cfg_user: assert property ( // [R7]
    apb_done && pwrite && !pprot[0] && paddr == OFF_CONC_CFG |=> $stable(concurrency_config))
    else $error("user write changed concurrency config");

  a_ccu_divert: assert property ( // [R9]
    accept && !misaligned && divert |=> ccu_req && !mem_req && state == ST_CCU)
    else $error("window access not diverted");

  a_align_nobus: assert property ( // [R21]
    accept && misaligned |=> align_trap && resp_fault && !mem_req && !ccu_req ##1 !align_trap)
    else $error("misaligned access started a cycle");

  a_ate_follow: assert property ( // [R19]
    apb_done && pwrite && pprot[0] && paddr == OFF_MODE_CTRL
      |=> translation_enable == $past(pwdata[CTRL_ATE_BIT]))
    else $error("translation enable did not follow write");

  a_fetch_order: assert property ( // [R13]
    accept && req_kind == KIND_FETCH |=> !cur_swap)
    else $error("fetch used swapped byte order");

endmodule // ls_addr_front_end

// ### include/ls_front_pkg.sv
// Shared constants and types for the load/store address front end
//
// Notes on behaviour
// [R1] Bus error with ready captures cycle address
// [R2] Read parity error with ready captures address
// [R3] Unsynchronised error cycles leave fault address undefined
// [R4] Fault address keeps bits 31..3 only
// [R5] After reset or trap, read re-arms capture
// [R6] Fault address register is read-only
// [R7] Concurrency config writable in supervisor only
// [R8] Both bits set selects internal unit
// [R9] Internal unit window accesses never reach memory; fetch, table walk and I/O window accesses still do
// [R10] Software keeps window base bit 12 clear
// [R11] Address sum wraps to 32 bits
// [R12] Big-endian select swaps bytes, supervisor writable
// [R13] Instruction fetches always little-endian
// [R14] Table walk accesses always little-endian
// [R15] Software flips bit 2 for entries
// [R16] Byte order also covers I/O accesses
// [R17] 128-bit and 64-bit alignment checks trap
// [R18] 32-bit and 16-bit alignment checks trap
// [R19] Reset clears translation enable; writes control it
// [R20] Four-Kbyte and four-Mbyte frames, size aligned
// [R21] Misaligned access starts no cycle, no capture
package ls_front_pkg;

  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h00;
  localparam logic [7:0] OFF_CONC_CFG = 8'h04;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // ******************************
  // Field positions and reset values
  // ******************************
  localparam int CFG_CO_BIT = 0;
  localparam int CFG_DO_BIT = 1;
  localparam int CFG_BASE_LSB = 13;
  localparam int CTRL_BE_BIT = 0;
  localparam int CTRL_ATE_BIT = 1;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int FAULT_LSB = 3;
  localparam int SMALL_PAGE_BITS = 12;
  localparam int LARGE_PAGE_BITS = 22;
  localparam logic [31:0] CFG_WMASK = 32'hffff_e003;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
  // Pins idle: ready and parity enable high (inactive), error low
  localparam logic [34:0] PIN_IDLE = {1'b1, 1'b0, 1'b1, 32'h0000_0000};

  // ******************************
  // Access types
  // ******************************
  typedef enum logic [2:0] {SZ_8, SZ_16, SZ_32, SZ_64, SZ_128} access_size_t;
  typedef enum logic [1:0] {KIND_DATA, KIND_FETCH, KIND_TABLE, KIND_IO} access_kind_t;

endpackage

// ### core/ls_align_check.sv
`timescale 1ns/1ps
// Alignment check for one load/store access
module ls_align_check (
  // Access
  input wire ls_front_pkg::access_size_t size,
  input wire logic [3:0] addr_low,
  // Result
  output logic misaligned
);
  import ls_front_pkg::*;

  // Low address bits that must be zero for each item size
  always_comb begin
    misaligned = 1'b0;
    unique case (size)
      SZ_8: misaligned = 1'b0;
      // [R18] short and word alignment
      SZ_16: misaligned = addr_low[0];
      SZ_32: misaligned = |addr_low[1:0];
      // [R17] double and quad alignment
      SZ_64: misaligned = |addr_low[2:0];
      SZ_128: misaligned = |addr_low[3:0];
      default: misaligned = 1'b1;
    endcase
  end

endmodule // ls_align_check

// ### core/ls_page_frame.sv
`timescale 1ns/1ps
// Physical address forming from a page frame of either size
module ls_page_frame (
  // Translation inputs
  input wire logic enable,
  input wire logic large_page,
  input wire logic [31:0] virt_addr,
  input wire logic [31:0] frame_base,
  // Result
  output logic [31:0] phys_addr
);
  import ls_front_pkg::*;

  // [R20] frame bits from base, offset from virtual address
  always_comb begin
    phys_addr = virt_addr;
    if (enable && large_page) begin
      phys_addr = {frame_base[31:LARGE_PAGE_BITS], virt_addr[LARGE_PAGE_BITS-1:0]};
    end else if (enable) begin
      phys_addr = {frame_base[31:SMALL_PAGE_BITS], virt_addr[SMALL_PAGE_BITS-1:0]};
    end
  end

endmodule // ls_page_frame

// ### tb/mem_bus_model.sv
// Behavioural model of the external memory bus behind the front end
`timescale 1ns/1ps
module mem_bus_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Cycle from the front end
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  // Commands from the bench
  input wire logic [1:0] delay,
  input wire logic inj_err,
  input wire logic inj_par,
  // Pins back to the front end
  output logic [31:0] mem_rdata,
  output logic burst_ready_in_n,
  output logic bus_error_in,
  output logic parity_check_enable_n
);
  localparam logic [31:0] MEM_K = 32'h3c3c_a5a5;
  logic [1:0] wait_cnt;

  // Answer after a chosen wait, pins held until the request drops
  // error flags with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_ready_in_n <= 1'b1;
      bus_error_in <= 1'b0;
      parity_check_enable_n <= 1'b1;
      mem_rdata <= 32'h0000_0000;
      wait_cnt <= 2'd0;
    end else if (mem_req && burst_ready_in_n) begin
      if (wait_cnt >= delay) begin
        burst_ready_in_n <= 1'b0;
        mem_rdata <= mem_addr ^ MEM_K;
        bus_error_in <= inj_err;
        parity_check_enable_n <= ~(inj_par & ~mem_write);
      end else begin
        wait_cnt <= wait_cnt + 2'd1;
      end
    end else if (!mem_req) begin
      // Released data lines keep changing so no stale value passes
      burst_ready_in_n <= 1'b1;
      bus_error_in <= 1'b0;
      parity_check_enable_n <= 1'b1;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= 2'd0;
    end
  end
endmodule // mem_bus_model

// ### tb/tb_ls_addr_front_end.sv
// Self-checking bench for the load/store address front end
`timescale 1ns/1ps
module tb_ls_addr_front_end;
  import ls_front_pkg::*;
  localparam logic [31:0] MEM_K = 32'h3c3c_a5a5;
  localparam logic [31:0] CCU_K = 32'h0f0f_1234;
  localparam logic [34:0] MIS = {3'b010, 32'h0};
  localparam logic [34:0] BUS = {3'b001, 32'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [2:0] pprot;
  logic [31:0] pwdata, prdata, req_base, req_offset, req_wdata, req_frame_base, resp_rdata;
  logic req_valid, req_write, req_large_page, req_ready, resp_valid, resp_fault;
  access_size_t req_size;
  access_kind_t req_kind;
  logic align_trap, bus_trap, mem_req, mem_write, ccu_req, ccu_write, ccu_ack;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, ccu_addr, ccu_wdata, ccu_rdata, r, a;
  logic burst_ready_in_n, bus_error_in, parity_check_enable_n, translation_enable;
  logic inj_err, inj_par, be, mem_req_d, ccu_req_d, ef;
  logic [1:0] delay;
  logic [31:0] seed = 32'h88496599;
  logic [33:0] apb_q[$];
  logic [34:0] rsp_q[$];
  logic [33:0] ea;
  logic [34:0] er;
  int n_mismatch = 0, check_count = 0, mem_cnt = 0, ccu_cnt = 0, c, cc;

  ls_addr_front_end ls_addr_front_end_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pprot, .prdata, .pready, .pslverr, .req_valid, .req_base, .req_offset,
    .req_size, .req_kind, .req_write, .req_wdata, .req_frame_base, .req_large_page,
    .req_ready, .resp_valid, .resp_rdata, .resp_fault, .align_trap, .bus_trap, .mem_req,
    .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .burst_ready_in_n, .bus_error_in,
    .parity_check_enable_n, .ccu_req, .ccu_write, .ccu_addr, .ccu_wdata, .ccu_ack,
    .ccu_rdata, .translation_enable);
  mem_bus_model mem_bus_model_i (.pclk, .presetn, .mem_req, .mem_write, .mem_addr, .delay,
    .inj_err, .inj_par, .mem_rdata, .burst_ready_in_n, .bus_error_in, .parity_check_enable_n);

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected memory read data, swapped only where byte order applies
  function automatic logic [34:0] md(input logic [31:0] x, input access_kind_t k);
    logic [31:0] v;
    v = x ^ MEM_K;
    if (be && (k == KIND_DATA || k == KIND_IO))
      v = {v[7:0], v[15:8], v[23:16], v[31:24]};
    return {3'b100, v};
  endfunction

  // Expected store lane: swapped per item size where byte order applies
  function automatic logic [31:0] ws(input logic [31:0] x);
    if (!be || !(req_kind == KIND_DATA || req_kind == KIND_IO) || req_size == SZ_8)
      return x;
    if (req_size == SZ_16)
      return {x[31:16], x[7:0], x[15:8]};
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // APB transfer; entry is {check data, slverr, data}
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      input logic sup, input logic [33:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pprot <= {2'b00, sup};
    apb_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One load; entry is {check data, align trap, bus trap, data}
  task automatic acc(input logic [31:0] b, input logic [31:0] o, input access_size_t s,
      input access_kind_t k, input logic [34:0] e);
    int n;
    r = xs();
    req_valid <= 1'b1;
    req_base <= b;
    req_offset <= o;
    req_size <= s;
    req_kind <= k;
    req_wdata <= r;
    delay <= r[1:0];
    rsp_q.push_back(e);
    n = 0;
    do begin @(posedge pclk); n++; end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    while (rsp_q.size() != 0 && n < 100) begin @(posedge pclk); n++; end
    if (n >= 100) n_mismatch++;
  endtask

  // ******************************
  // Monitors and far-side responders
  // ******************************
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      ea = apb_q.pop_front();
      check({2'b0, pslverr, ea[33] ? prdata : ea[31:0]}, {2'b0, ea[32:0]});
    end
    if (resp_valid === 1'b1) begin
      er = rsp_q.pop_front();
      // Fault flag follows either trap or an injected error
      ef = er[33] | er[32] | inj_err;
      check({resp_fault, align_trap, bus_trap, er[34] ? resp_rdata : er[31:0]},
        {ef, er[33:0]});
    end
    if (mem_req === 1'b1 && !mem_req_d)
      check({3'b0, mem_wdata}, {3'b0, ws(req_wdata)});
    if (ccu_req === 1'b1 && !ccu_req_d)
      check({3'b0, ccu_wdata}, {3'b0, ws(req_wdata)});
    if (mem_req === 1'b1 && burst_ready_in_n && !mem_req_d) mem_cnt++;
    if (ccu_req === 1'b1 && !ccu_ack && !ccu_req_d) ccu_cnt++;
    mem_req_d <= mem_req;
    ccu_req_d <= ccu_req;
    ccu_ack <= ccu_req & ~ccu_ack;
    ccu_rdata <= ccu_addr ^ CCU_K;
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #3000000;
    n_mismatch++;
    conclude();
  end

  // ******************************
  // Scenarios
  // ******************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pprot} = '0;
    {req_valid, req_base, req_offset, req_write, req_wdata, req_frame_base} = '0;
    {req_large_page, inj_err, inj_par, be, delay} = '0;
    req_size = SZ_8;
    req_kind = KIND_DATA;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({34'h0, translation_enable}, 35'h0);
    apb(0, OFF_STATUS, 0, 1, 34'h2_0000_0000);
    apb(0, OFF_FAULT_ADDR, 0, 1, {2'b10, FAULT_RESET});
    apb(0, OFF_STATUS, 0, 1, 34'h2_0000_0001);
    apb(1, OFF_FAULT_ADDR, 32'hffff_ffff, 1, 34'h1_0000_0000);
    apb(0, 8'h10, 0, 1, 34'h1_0000_0000);
    apb(1, OFF_CONC_CFG, 32'hffff_ffff, 0, 34'h1_0000_0000);
    apb(0, OFF_CONC_CFG, 0, 0, {2'b10, CFG_RESET});
    apb(1, OFF_CONC_CFG, 32'hffff_ffff, 1, 34'h0);
    apb(0, OFF_CONC_CFG, 0, 0, {2'b10, CFG_WMASK});
    // Window off again so random addresses reach memory
    apb(1, OFF_CONC_CFG, 0, 1, 34'h0);
    $display("registers done");
    // Every size against every low address nibble
    for (int s = 0; s < 5; s++) begin
      for (int lo = 0; lo < 16; lo++) begin
        r = xs();
        a = {r[31:4], lo[3:0]};
        c = mem_cnt;
        if ((lo & ((1 << s) - 1)) != 0) begin
          acc(a, 0, access_size_t'(s), KIND_DATA, MIS);
          check(35'(mem_cnt), 35'(c));
        end else
          acc(a, 0, access_size_t'(s), KIND_DATA, s == 2 ? md(a, KIND_DATA) : 35'h0);
      end
    end
    acc(32'hffff_fff0, 32'h0000_0020, SZ_32, KIND_DATA, md(32'h10, KIND_DATA));
    $display("alignment done");
    apb(1, OFF_MODE_CTRL, 32'h1, 0, 34'h1_0000_0000);
    apb(1, OFF_MODE_CTRL, 32'h1, 1, 34'h0);
    be = 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = xs();
      acc({r[31:2], 2'b00}, 0, SZ_32, access_kind_t'(k),
        md({r[31:2], 2'b00}, access_kind_t'(k)));
    end
    // Table entry reached as data: software flips address bit 2
    a = (a & 32'hffff_fffc) ^ 32'h0000_0004;
    acc(a, 0, SZ_32, KIND_DATA, md(a, KIND_DATA));
    be = 1'b0;
    apb(1, OFF_MODE_CTRL, 32'h2, 1, 34'h0);
    check({34'h0, translation_enable}, 35'h1);
    for (int lp = 0; lp < 2; lp++) begin
      r = xs();
      req_large_page <= lp[0];
      req_frame_base <= lp ? {r[31:22], 22'h0} : {r[31:12], 12'h0};
      a = {xs() & 32'hffff_fffc};
      acc(a, 0, SZ_32, KIND_DATA, md(lp ? {r[31:22], a[21:0]} : {r[31:12], a[11:0]},
        KIND_DATA));
      acc(a, 0, SZ_32, KIND_TABLE, md(a, KIND_TABLE));
    end
    apb(1, OFF_MODE_CTRL, 32'h0, 1, 34'h0);
    check({34'h0, translation_enable}, 35'h0);
    $display("byte order and translation done");
    for (int m = 0; m < 4; m++) begin
      r = xs();
      a = {r[31:13], 13'h0};
      // Window base written with its bit 12 clear
      apb(1, OFF_CONC_CFG, a | m, 1, 34'h0);
      c = mem_cnt;
      cc = ccu_cnt;
      acc(a, 32'h1ffc, SZ_32, KIND_DATA, m == 3 ? {3'b100, (a + 32'h1ffc) ^ CCU_K}
        : md(a + 32'h1ffc, KIND_DATA));
      check(35'(mem_cnt - c), m == 3 ? 35'h0 : 35'h1);
      check(35'(ccu_cnt - cc), m == 3 ? 35'h1 : 35'h0);
      acc(a, 32'h2000, SZ_32, KIND_DATA, md(a + 32'h2000, KIND_DATA));
    end
    apb(1, OFF_CONC_CFG, 0, 1, 34'h0);
    $display("concurrency done");
    a = xs() & 32'hffff_fffc;
    inj_err <= 1'b1;
    acc(a, 0, SZ_32, KIND_DATA, BUS);
    acc(xs() & 32'hffff_fffc, 0, SZ_32, KIND_DATA, 35'h0);
    inj_err <= 1'b0;
    apb(0, OFF_STATUS, 0, 1, 34'h2_0000_0000);
    apb(1, OFF_FAULT_ADDR, 32'h0, 1, 34'h1_0000_0000);
    apb(0, OFF_FAULT_ADDR, 0, 0, {2'b10, a[31:3], 3'b000});
    a = xs() & 32'hffff_fffc;
    inj_par <= 1'b1;
    acc(a, 0, SZ_32, KIND_DATA, BUS);
    inj_par <= 1'b0;
    acc(a | 32'h1, 0, SZ_32, KIND_DATA, MIS);
    apb(0, OFF_FAULT_ADDR, 0, 1, {2'b10, a[31:3], 3'b000});
    $display("fault capture done");
    conclude();
  end
endmodule // tb_ls_addr_front_end
